// file: design/drc_defines.vh
// Timing and geometry constants for the strobe memory controller
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH
`define DRC_CLK_NS 40
`define DRC_ADDR_BITS 12
`define DRC_MUX_BITS 6
`define DRC_ROWS 64
`define DRC_INIT_CYCLES 8
`define DRC_T_RC_NS 380
`define DRC_T_RMW_NS 470
`define DRC_T_RAS_NS 250
`define DRC_T_RP_NS 120
`define DRC_T_CAS_NS 165
`define DRC_T_RCD_NS 35
`define DRC_T_RAC_NS 250
`define DRC_T_CAC_NS 165
`define DRC_T_CWD_NS 90
`define DRC_T_RWD_NS 175
`define DRC_T_WP_NS 75
`define DRC_T_WL_NS 100
`define DRC_T_OFF_NS 60
`define DRC_T_REFRESH_US 1000
`define DRC_CYC_MIN(ns) (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_CYC_MAX(ns) ((ns) / `DRC_CLK_NS)
`endif

// file: design/drc_timer.v
// Down-counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ps
`default_nettype none
module drc_timer #(
	parameter W = 16
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire load_in,
	input wire [W-1:0] count_in,
	output reg done_out
);
	reg [W-1:0] cnt_q;
	reg run_q;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (load_in) begin
				cnt_q <= count_in;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					done_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: design/drc_ctrl.v
// Host controller driving a 4096x1 strobe-timed dynamic memory
// Overview of operation
// - Read, write, read-modify-write, row-only refresh
// - Eight refresh cycles after power-up
// - Row strobe period at least 380 ns
// - Read-modify-write lasts at least 470 ns
// - Row strobe low 250 to 4000 ns
// - Row strobe high at least 120 ns
// - Column strobe low 165 to 4000 ns
// - Column strobe 35 to 85 ns after row
// - Write pulse 75 ns, 100 ns before release
`timescale 1ns/1ps
`default_nettype none
`include "drc_defines.vh"
module drc_ctrl #(
	parameter REFRESH_CYCLES = (`DRC_T_REFRESH_US * 1000 / `DRC_CLK_NS)
		/ `DRC_ROWS
) (
	// Clock and reset
	input wire sys_clk_in,
	input wire reset_n_in,
	// User request port
	input wire req_valid_in,
	input wire [1:0] req_op_in,
	input wire [`DRC_ADDR_BITS-1:0] req_addr_in,
	input wire req_wdata_in,
	output reg req_ready_out,
	output reg rsp_valid_out,
	output reg rsp_rdata_out,
	output reg init_done_out,
	// Memory pins
	output reg [`DRC_MUX_BITS-1:0] mux_addr_out,
	output reg row_strobe_n_out,
	output reg col_strobe_n_out,
	output reg chip_sel_n_out,
	output reg write_n_out,
	output reg data_in_out,
	input wire data_out_in
);
	localparam OP_READ = 2'h0;
	localparam OP_WRITE = 2'h1;
	localparam OP_RMW = 2'h2;
	localparam C_RCD = `DRC_CYC_MIN(`DRC_T_RCD_NS);
	localparam C_RAS = `DRC_CYC_MIN(`DRC_T_RAS_NS);
	localparam C_RP = `DRC_CYC_MIN(`DRC_T_RP_NS);
	localparam C_RC = `DRC_CYC_MIN(`DRC_T_RC_NS);
	localparam C_RMW = `DRC_CYC_MIN(`DRC_T_RMW_NS);
	localparam C_CAC = `DRC_CYC_MIN(`DRC_T_CAC_NS) + 1;
	localparam C_CWD = `DRC_CYC_MIN(`DRC_T_CWD_NS);
	localparam C_WL = `DRC_CYC_MIN(`DRC_T_WL_NS);
	localparam C_WP = `DRC_CYC_MIN(`DRC_T_WP_NS);
	localparam ST_IDLE = 3'h0;
	localparam ST_RCD = 3'h1;
	localparam ST_CAS = 3'h2;
	localparam ST_WR = 3'h3;
	localparam ST_HOLD = 3'h4;
	localparam ST_PRE = 3'h5;
	localparam TW = 16;

	reg [2:0] st_q;
	reg [7:0] cnt_q;
	reg [7:0] cyc_q;
	reg [7:0] need_q;
	reg [1:0] op_q;
	reg refresh_q;
	reg [`DRC_ADDR_BITS-1:0] addr_q;
	reg wdata_q;
	reg [5:0] ref_row_q;
	reg [3:0] init_cnt_q;
	reg ref_pend_q;
	reg ref_arm_q;
	wire ref_tick;
	localparam integer REF_LOAD = REFRESH_CYCLES - 1;

	// Refresh interval timer, reloaded on every tick
	drc_timer #(.W(TW)) u_ref_timer (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.load_in(ref_tick | ~ref_arm_q),
		.count_in(REF_LOAD[TW-1:0]),
		.done_out(ref_tick)
	);

	// First load after reset starts the timer
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			ref_arm_q <= 1'b0;
		else
			ref_arm_q <= 1'b1;
	end

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			cyc_q <= 8'h00;
			need_q <= 8'h00;
			op_q <= 2'h0;
			refresh_q <= 1'b0;
			addr_q <= {`DRC_ADDR_BITS{1'b0}};
			wdata_q <= 1'b0;
			ref_row_q <= 6'h00;
			init_cnt_q <= 4'h0;
			ref_pend_q <= 1'b0;
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= 1'b0;
			init_done_out <= 1'b0;
			mux_addr_out <= 6'h00;
			row_strobe_n_out <= 1'b1;
			col_strobe_n_out <= 1'b1;
			chip_sel_n_out <= 1'b1;
			write_n_out <= 1'b1;
			data_in_out <= 1'b0;
		end else begin
			rsp_valid_out <= 1'b0;
			req_ready_out <= 1'b0;
			cnt_q <= cnt_q + 8'h01;
			if (st_q != ST_IDLE)
				cyc_q <= cyc_q + 8'h01;
			if (ref_tick)
				ref_pend_q <= 1'b1;
			case (st_q)
			ST_IDLE: begin
				cyc_q <= 8'h01;
				cnt_q <= 8'h01;
				if (req_valid_in && req_ready_out) begin
					refresh_q <= 1'b0;
					op_q <= req_op_in;
					addr_q <= req_addr_in;
					wdata_q <= req_wdata_in;
					// Row half first
					mux_addr_out <= req_addr_in[11:6];
					row_strobe_n_out <= 1'b0;
					chip_sel_n_out <= 1'b0;
					// Data and write lead the column strobe
					data_in_out <= req_wdata_in;
					if (req_op_in == OP_WRITE)
						write_n_out <= 1'b0;
					need_q <= (req_op_in == OP_RMW) ? C_RMW[7:0]
						: C_RC[7:0];
					st_q <= ST_RCD;
				end else if (!init_done_out || ref_pend_q || ref_tick) begin
					// Row-only refresh cycle
					refresh_q <= 1'b1;
					// A tick landing on a pending one stays pending
					ref_pend_q <= ref_pend_q & ref_tick;
					mux_addr_out <= ref_row_q;
					ref_row_q <= ref_row_q + 6'h01;
					row_strobe_n_out <= 1'b0;
					need_q <= C_RC[7:0];
					st_q <= ST_HOLD;
				end else begin
					req_ready_out <= 1'b1;
				end
			end
			ST_RCD: begin
				if (cnt_q >= C_RCD[7:0]) begin
					mux_addr_out <= addr_q[5:0];
					col_strobe_n_out <= 1'b0;
					cnt_q <= 8'h01;
					st_q <= ST_CAS;
				end
			end
			ST_CAS: begin
				// Capture read data after column access
				if (cnt_q == C_CAC[7:0] && op_q != OP_WRITE)
					rsp_rdata_out <= data_out_in;
				if (op_q == OP_RMW && cnt_q >= C_CAC[7:0]
					&& cnt_q >= C_CWD[7:0]
					&& cyc_q >= `DRC_CYC_MIN(`DRC_T_RWD_NS)) begin
					data_in_out <= wdata_q;
					write_n_out <= 1'b0;
					cnt_q <= 8'h01;
					st_q <= ST_WR;
				end else if (op_q != OP_RMW && cnt_q >= C_CAC[7:0]
					&& cnt_q >= C_WL[7:0]) begin
					st_q <= ST_HOLD;
				end
			end
			ST_WR: begin
				if (cnt_q >= C_WL[7:0] && cnt_q >= C_WP[7:0])
					st_q <= ST_HOLD;
			end
			ST_HOLD: begin
				if (cyc_q >= C_RAS[7:0]
					&& cyc_q + C_RP[7:0] >= need_q) begin
					// Release strobes together
					row_strobe_n_out <= 1'b1;
					col_strobe_n_out <= 1'b1;
					write_n_out <= 1'b1;
					chip_sel_n_out <= 1'b1;
					cnt_q <= 8'h01;
					st_q <= ST_PRE;
				end
			end
			ST_PRE: begin
				if (cnt_q >= C_RP[7:0] && cyc_q >= need_q) begin
					if (refresh_q) begin
						if (!init_done_out) begin
							init_cnt_q <= init_cnt_q + 4'h1;
							if (init_cnt_q == `DRC_INIT_CYCLES - 1)
								init_done_out <= 1'b1;
						end
					end else begin
						rsp_valid_out <= 1'b1;
					end
					st_q <= ST_IDLE;
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: test/drc_sva.sv
// Strobe timing checker for the memory controller
`timescale 1ns/1ps
`default_nettype none
module drc_sva (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire req_valid_in,
	input wire req_ready_out,
	input wire rsp_valid_out,
	input wire row_strobe_n_out,
	input wire col_strobe_n_out,
	input wire write_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence row_go;
		$fell(row_strobe_n_out);
	endsequence
	sequence col_go;
		$fell(col_strobe_n_out);
	endsequence
	a_row_low_min: assert property (
		row_go |-> !row_strobe_n_out[*7]) else $error("row low short");
	a_row_low_max: assert property (
		row_go |-> ##[1:100] row_strobe_n_out) else $error("row low long");
	a_row_high_min: assert property (
		$rose(row_strobe_n_out) |-> row_strobe_n_out[*3])
		else $error("precharge short");
	a_col_low_min: assert property (
		col_go |-> !col_strobe_n_out[*5]) else $error("col low short");
	a_col_low_max: assert property (
		col_go |-> ##[1:100] col_strobe_n_out) else $error("col low long");
	a_col_after_row: assert property (
		col_go |-> !$past(row_strobe_n_out)) else $error("col before row");
	a_write_lead: assert property (
		$fell(write_n_out) |-> (!row_strobe_n_out && !write_n_out)[*2]
		##1 (!row_strobe_n_out && !col_strobe_n_out && !write_n_out))
		else $error("write lead short");
	a_write_in_row: assert property (
		!write_n_out |-> !row_strobe_n_out) else $error("write outside row");
	a_rsp_bound: assert property (
		req_valid_in && req_ready_out |-> ##[12:15] rsp_valid_out)
		else $error("no response");
endmodule
bind drc_ctrl drc_sva drc_sva_i (.sys_clk_in(sys_clk_in),
	.reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
	.req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
	.row_strobe_n_out(row_strobe_n_out),
	.col_strobe_n_out(col_strobe_n_out), .write_n_out(write_n_out));
`default_nettype wire

// file: test/drc_mem_model.sv
// Behavioural 4096x1 strobe memory
`timescale 1ns/1ps
`default_nettype none
module drc_mem_model (
	input wire logic [5:0] mux_addr_in,
	input wire logic row_strobe_n_in,
	input wire logic col_strobe_n_in,
	input wire logic chip_sel_n_in,
	input wire logic write_n_in,
	input wire logic data_in_in,
	output logic data_out_out
);
	logic mem_q [0:4095];
	logic [5:0] row_q;
	logic [11:0] adr_q;
	logic last_q = 1'b0;
	logic drv_q = 1'b0;
	// Undriven output shows inverse of last value
	assign data_out_out = drv_q ? last_q : ~last_q;
	// Latch just after the edge, clear of same-step pin updates
	always @(negedge row_strobe_n_in) #1 row_q = mux_addr_in;
	always @(negedge col_strobe_n_in) begin
		#1;
		adr_q = {row_q, mux_addr_in};
		if (!write_n_in) begin
			mem_q[adr_q] = data_in_in;
			last_q <= #165 data_in_in;
		end else begin
			last_q <= #165 mem_q[adr_q];
		end
		drv_q <= #165 !chip_sel_n_in;
	end
	always @(negedge write_n_in) begin
		if (!col_strobe_n_in) mem_q[adr_q] = data_in_in;
	end
	always @(posedge col_strobe_n_in) drv_q <= #60 1'b0;
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the strobe memory controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk_in = 0, reset_n_in = 0, req_valid_in = 0, req_wdata_in = 0;
	logic [1:0] req_op_in = 2'h0;
	logic [11:0] req_addr_in = 12'h000;
	wire req_ready_out, rsp_valid_out, rsp_rdata_out, init_done_out;
	wire row_n, col_n, sel_n, wr_n, din, dout;
	wire [5:0] mux;
	int bad_count = 0, total_checks = 0, rows = 0, init_rows = 0;
	drc_ctrl #(.REFRESH_CYCLES(40)) drc_ctrl_i (.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in), .req_valid_in(req_valid_in),
		.req_op_in(req_op_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
		.init_done_out(init_done_out), .mux_addr_out(mux),
		.row_strobe_n_out(row_n), .col_strobe_n_out(col_n),
		.chip_sel_n_out(sel_n), .write_n_out(wr_n), .data_in_out(din),
		.data_out_in(dout));
	drc_mem_model drc_mem_model_i (.mux_addr_in(mux), .row_strobe_n_in(row_n),
		.col_strobe_n_in(col_n), .chip_sel_n_in(sel_n), .write_n_in(wr_n),
		.data_in_in(din), .data_out_out(dout));
	initial forever #20 sys_clk_in = ~sys_clk_in;
	always @(negedge row_n) begin
		rows++;
		if (init_done_out !== 1'b1) init_rows++;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready();
		int n;
		for (n = 0; req_ready_out !== 1'b1; n++) begin
			if (n > 400) begin
				check(16'h0, 16'h1);
				stop_test();
			end
			@(posedge sys_clk_in);
		end
	endtask
	task automatic op(input logic [1:0] o, input logic [11:0] a,
		input logic d, input logic exp, input int lat);
		int n;
		wait_ready();
		req_valid_in <= 1'b1;
		req_op_in <= o;
		req_addr_in <= a;
		req_wdata_in <= d;
		@(posedge sys_clk_in);
		wait_ready();
		req_valid_in <= 1'b0;
		for (n = 1; n < 20; n++) begin
			@(posedge sys_clk_in);
			if (rsp_valid_out === 1'b1) break;
		end
		check(n[15:0], lat[15:0]);
		if (o != 2'h1) check({15'h0, rsp_rdata_out}, {15'h0, exp});
	endtask
	task automatic t_init();
		int n;
		for (n = 0; init_done_out !== 1'b1 && n < 300; n++) @(posedge sys_clk_in);
		check({15'h0, init_done_out}, 16'h1);
		check({15'h0, init_rows >= 8}, 16'h1);
	endtask
	task automatic t_write_read();
		op(2'h1, 12'hFFF, 1'b1, 1'b1, 12);
		op(2'h1, 12'h000, 1'b0, 1'b0, 12);
		op(2'h0, 12'hFFF, 1'b0, 1'b1, 12);
		op(2'h3, 12'h000, 1'b0, 1'b0, 12);
	endtask
	task automatic t_rmw();
		op(2'h2, 12'hFFF, 1'b0, 1'b1, 15);
		op(2'h2, 12'hFFF, 1'b1, 1'b0, 15);
		op(2'h0, 12'hFFF, 1'b0, 1'b1, 12);
	endtask
	task automatic t_refresh();
		int r;
		r = rows;
		repeat (400) @(posedge sys_clk_in);
		check({15'h0, rows - r >= 9}, 16'h1);
		op(2'h0, 12'h000, 1'b0, 1'b0, 12);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		t_init();
		t_write_read();
		t_rmw();
		t_refresh();
		stop_test();
	end
endmodule
`default_nettype wire
